// >>> hdl/prom_read_pkg.sv
// Shared constants, types and decoding for the configuration read port.
// Assumes a single 10 MHz system clock; all pins are synchronous to it.
package prom_read_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Clock and timing
    localparam int CLOCK_PERIOD_NS   = 100;      // System clock period
    localparam int RESET_HOLD_NS     = 1000;     // Internal reset pull time
    // Least time, so round up to whole cycles
    localparam int RESET_HOLD_CYCLES = (RESET_HOLD_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam logic [3:0] RESET_HOLD_COUNT = 4'(RESET_HOLD_CYCLES);
    localparam int MAX_CFG_CLOCK_MHZ = 33;       // Top pin clock rate, both modes

    ////////////////////////////////////////////////////////////////////////
    // Address widths and capacities
    localparam int COUNT_WIDTH = 22;             // Bit counter for the largest part
    localparam int ADDR_WIDTH  = 19;             // Byte address for the largest part
    localparam int BIT_SEL_LSB = 0;              // Bit-in-byte field of the counter
    localparam int BIT_SEL_MSB = 2;
    localparam logic [COUNT_WIDTH-1:0] COUNT_RESET = 22'h000000;
    localparam logic [1:0] CAP_4M   = 2'h0;      // Capacity strap codes
    localparam logic [1:0] CAP_2M   = 2'h1;
    localparam logic [1:0] CAP_1M   = 2'h2;
    localparam logic [1:0] CAP_512K = 2'h3;
    localparam logic [COUNT_WIDTH-1:0] LAST_BIT_4M   = 22'h3FFFFF;
    localparam logic [COUNT_WIDTH-1:0] LAST_BIT_2M   = 22'h1FFFFF;
    localparam logic [COUNT_WIDTH-1:0] LAST_BIT_1M   = 22'h0FFFFF;
    localparam logic [COUNT_WIDTH-1:0] LAST_BIT_512K = 22'h07FFFF;
    localparam int BYTE_SHIFT = 3;               // Bits per byte, as a shift

    ////////////////////////////////////////////////////////////////////////
    // Data pin drive
    localparam logic [7:0] OE_N_ALL_OFF  = 8'hFF;
    localparam logic [7:0] OE_N_ALL_ON   = 8'h00;
    localparam logic [7:0] OE_N_SERIAL   = 8'hFE;
    localparam logic [6:0] OE_N_UPPER_OFF = 7'h7F;
    localparam logic [7:0] DATA_IDLE     = 8'h00;

    typedef struct packed {
        logic [7:0] value;                       // Level on each data pin
        logic [7:0] oe_n;                        // Low where the pin is driven
    } data_drive_type;

    // Port life cycle, one-hot
    typedef enum logic [3:0] {
        ST_RESET   = 4'h1,                       // Internal reset, pulling the pin
        ST_STANDBY = 4'h2,                       // Chip enable high
        ST_READ    = 4'h4,                       // Streaming data
        ST_DONE    = 4'h8                        // Past terminal count
    } port_state_type;

    // Terminal count of the counter for a capacity and a mode
    function automatic logic [COUNT_WIDTH-1:0] last_count(input logic [1:0] cap,
                                                          input logic       par);
        logic [COUNT_WIDTH-1:0] bits;
        bits = LAST_BIT_4M;
        case (cap)
            CAP_4M:   bits = LAST_BIT_4M;
            CAP_2M:   bits = LAST_BIT_2M;
            CAP_1M:   bits = LAST_BIT_1M;
            CAP_512K: bits = LAST_BIT_512K;
            default:  bits = LAST_BIT_4M;
        endcase
        return par ? (bits >> BYTE_SHIFT) : bits;
    endfunction

    // Byte address of the array for a counter value
    function automatic logic [ADDR_WIDTH-1:0] byte_addr(input logic [COUNT_WIDTH-1:0] cnt,
                                                        input logic                   par);
        logic [COUNT_WIDTH-1:0] addr;
        addr = par ? cnt : (cnt >> BYTE_SHIFT);
        return addr[ADDR_WIDTH-1:0];
    endfunction

endpackage

// >>> hdl/cfg_clock_edge.sv
// Rising-edge detector for the configuration clock pin.
// Assumes the pin is already synchronous to the system clock.
`timescale 1ns/1ps
module cfg_clock_edge (
    input  wire logic clock_in,
    input  wire logic reset_n_in,
    input  wire logic config_clock_in,
    output logic      rise_out
);
    logic last_level_ff;                         // Level seen one cycle ago

    ////////////////////////////////////////////////////////////////////////
    // Remember the previous pin level
    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            last_level_ff <= 1'b1;               // No false edge after reset
        end else begin
            last_level_ff <= config_clock_in;
        end
    end

    // One-cycle pulse on a low-to-high step
    assign rise_out = config_clock_in & ~last_level_ff;
endmodule

// >>> hdl/cfg_data_format.sv
// Shapes one stored byte into the drive of the eight data pins.
// Pure logic; the caller registers the result.
`timescale 1ns/1ps
module cfg_data_format (
    input  wire logic [7:0]                    byte_in,
    input  wire logic [2:0]                    bit_sel_in,
    input  wire logic                          parallel_in,
    input  wire logic                          drive_in,
    output prom_read_pkg::data_drive_type      drive_out
);
    ////////////////////////////////////////////////////////////////////////
    // Serial sends the top bit of each byte first
    always_comb begin
        drive_out.value = prom_read_pkg::DATA_IDLE;
        drive_out.oe_n  = prom_read_pkg::OE_N_ALL_OFF;
        if (!drive_in) begin
            // Released: every pin floats
            drive_out.oe_n = prom_read_pkg::OE_N_ALL_OFF;
        end else if (parallel_in) begin
            drive_out.value = byte_in;
            drive_out.oe_n  = prom_read_pkg::OE_N_ALL_ON;
        end else begin
            // Only the lowest pin carries the serial bit
            drive_out.value = {7'h00, byte_in[3'h7 - bit_sel_in]};
            drive_out.oe_n  = prom_read_pkg::OE_N_SERIAL;
        end
    end
endmodule

// >>> hdl/config_prom_read_port.sv
// Read-out port of a configuration memory: address counter, pin control,
// cascade output and data pin drive.
// Assumes an external array with combinational byte read, and all pins
// synchronous to the 10 MHz system clock.
//
// Operation
// [R1] Count up on clock edge when enabled
// [R2] Low output enable holds counter reset
// [R3] Low output enable floats data pins
// [R4] Pull output enable low during reset
// [R5] Output enable polarity is fixed low
// [R6] Chip enable high: standby, reset, float
// [R7] Serial: lowest pin only, rest float
// [R8] Parallel: eight bits every clock period
// [R9] First data appears without clock edge
// [R10] Next data follows each rising edge
// [R11] Receiver captures on following rising edge
// [R12] Master receiver supplies exact pulse count
// [R13] Works from free-running slave oscillator
// [R14] Serial clock up to 33 MHz; the pin is sampled at 10 MHz, so the counted clock stays under 5 MHz
// [R15] Parallel clock up to 33 MHz; the pin is sampled at 10 MHz, so the counted clock stays under 5 MHz
// [R16] Four selectable memory capacities
// [R17] Cascade output feeds next chip enable
// [R18] Cascade low when enabled and past count
// [R19] Float data pins after terminal count
// [R20] Counter holds past terminal count
`timescale 1ns/1ps
module config_prom_read_port (
    input  wire logic                               clock_in,
    input  wire logic                               reset_n_in,
    input  wire logic                               config_clock_in,
    input  wire logic                               chip_enable_n_in,
    input  wire logic                               oe_reset_in,
    input  wire logic                               parallel_mode_in,
    input  wire logic [1:0]                         capacity_sel_in,
    input  wire logic [7:0]                         array_data_in,
    output logic      [prom_read_pkg::ADDR_WIDTH-1:0] array_addr_out,
    output logic      [7:0]                         config_byte_out,
    output logic      [7:0]                         config_byte_oe_n_out,
    output logic                                    oe_reset_out,
    output logic                                    oe_reset_oe_n_out,
    output logic                                    cascade_enable_out_n,
    output logic                                    standby_out
);
    ////////////////////////////////////////////////////////////////////////
    // Declarations
    logic [prom_read_pkg::COUNT_WIDTH-1:0] count_ff;      // Bit or byte counter
    logic [prom_read_pkg::COUNT_WIDTH-1:0] nxt_count;
    logic [prom_read_pkg::COUNT_WIDTH-1:0] last_cnt;      // Terminal count
    logic                                  past_tc_ff;    // Counted beyond the end
    logic                                  nxt_past_tc;
    logic [3:0]                            hold_cnt_ff;   // Internal reset timer
    logic                                  pull_low_ff;   // Driving the shared pin
    logic                                  straps_ok_ff;  // Straps captured
    logic                                  parallel_ff;   // Captured mode
    logic [1:0]                            capacity_ff;   // Captured size
    logic                                  clk_rise;      // Pin clock edge pulse
    logic                                  run;           // Enabled for reading
    prom_read_pkg::data_drive_type         drive_nxt;     // Formatted pin drive
    prom_read_pkg::data_drive_type         drive_ff;      // Registered pin drive
    prom_read_pkg::port_state_type         state;         // Decoded life cycle
    logic                                  cascade_n_ff;
    logic                                  standby_ff;
    logic [prom_read_pkg::ADDR_WIDTH-1:0]  addr_ff;

    ////////////////////////////////////////////////////////////////////////
    // Pin clock edge
    // [R14] Pin clock sampled, limiting rate
    // The pin is sampled at 10 MHz, so the counted pin clock must stay
    // well below half that; the 33 MHz figure is the pin-level target.
    cfg_clock_edge u_edge (
        .clock_in        (clock_in),
        .reset_n_in      (reset_n_in),
        .config_clock_in (config_clock_in),
        .rise_out        (clk_rise)
    );

    ////////////////////////////////////////////////////////////////////////
    // Strap capture after release, never inside the reset itself
    // [R16] Capacity selection captured once
    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            straps_ok_ff <= 1'b0;
            parallel_ff  <= 1'b0;
            capacity_ff  <= prom_read_pkg::CAP_4M;
        end else if (!straps_ok_ff) begin
            straps_ok_ff <= 1'b1;
            parallel_ff  <= parallel_mode_in;
            capacity_ff  <= capacity_sel_in;
        end
    end

    assign last_cnt = prom_read_pkg::last_count(capacity_ff, parallel_ff);

    ////////////////////////////////////////////////////////////////////////
    // Internal reset timer and open-drain pull
    // [R4] Hold shared pin low while resetting
    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            hold_cnt_ff <= prom_read_pkg::RESET_HOLD_COUNT;
            pull_low_ff <= 1'b1;
        end else if (hold_cnt_ff != 4'h0) begin
            hold_cnt_ff <= hold_cnt_ff - 4'h1;
            pull_low_ff <= (hold_cnt_ff != 4'h1);
        end else begin
            pull_low_ff <= 1'b0;
        end
    end

    // Open drain: only ever a low level, enable low while pulling
    assign oe_reset_out      = 1'b0;
    assign oe_reset_oe_n_out = ~pull_low_ff;

    ////////////////////////////////////////////////////////////////////////
    // Enable decode
    // [R5] Pin read as active low, no inversion option
    assign run = !chip_enable_n_in && oe_reset_in && straps_ok_ff;

    // Life cycle view for the data drive and the checks
    always_comb begin
        state = prom_read_pkg::ST_READ;
        case (1'b1)
            pull_low_ff || !straps_ok_ff: state = prom_read_pkg::ST_RESET;
            chip_enable_n_in:             state = prom_read_pkg::ST_STANDBY;
            past_tc_ff:                   state = prom_read_pkg::ST_DONE;
            default:                      state = prom_read_pkg::ST_READ;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Next counter value
    always_comb begin
        nxt_count   = count_ff;
        nxt_past_tc = past_tc_ff;
        if (chip_enable_n_in || !oe_reset_in) begin
            // [R2] Counter back to start
            // [R6] Standby clears counter
            nxt_count   = prom_read_pkg::COUNT_RESET;
            nxt_past_tc = 1'b0;
        end else if (run && clk_rise && !past_tc_ff) begin
            if (count_ff == last_cnt) begin
                // [R20] Stop at end, no wrap
                nxt_past_tc = 1'b1;
            end else begin
                // [R1] Advance on pin clock edge
                // [R13] Free-running clock simply saturates
                nxt_count = count_ff + 22'h000001;
            end
        end
    end

    // Counter and byte address registers
    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            count_ff   <= prom_read_pkg::COUNT_RESET;
            past_tc_ff <= 1'b0;
            addr_ff    <= '0;
        end else begin
            count_ff   <= nxt_count;
            past_tc_ff <= nxt_past_tc;
            addr_ff    <= prom_read_pkg::byte_addr(nxt_count, parallel_ff);
        end
    end

    assign array_addr_out = addr_ff;

    ////////////////////////////////////////////////////////////////////////
    // Data pin drive
    // [R7] Serial keeps upper pins floating
    // [R8] Parallel drives the whole byte
    cfg_data_format u_format (
        .byte_in     (array_data_in),
        .bit_sel_in  (count_ff[prom_read_pkg::BIT_SEL_MSB:prom_read_pkg::BIT_SEL_LSB]),
        .parallel_in (parallel_ff),
        .drive_in    (state == prom_read_pkg::ST_READ && run),
        .drive_out   (drive_nxt)
    );

    // Drive register; the address register lags the counter by nothing,
    // so the byte read here always matches the current count.
    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            drive_ff.value <= prom_read_pkg::DATA_IDLE;
            drive_ff.oe_n  <= prom_read_pkg::OE_N_ALL_OFF;
        end else if (!oe_reset_in || chip_enable_n_in || past_tc_ff) begin
            // [R3] Float on output enable low
            // [R19] Float after the end for the next device
            drive_ff.value <= prom_read_pkg::DATA_IDLE;
            drive_ff.oe_n  <= prom_read_pkg::OE_N_ALL_OFF;
        end else begin
            // [R9] First byte shows once enabled
            // [R10] New value two cycles after each edge
            // [R11] Held a full pin clock period
            drive_ff <= drive_nxt;
        end
    end

    assign config_byte_out      = drive_ff.value;
    assign config_byte_oe_n_out = drive_ff.oe_n;

    ////////////////////////////////////////////////////////////////////////
    // Cascade and standby status
    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            cascade_n_ff <= 1'b1;
            standby_ff   <= 1'b0;
        end else begin
            // [R18] Low only when enabled and past end
            // [R17] Passes the enable down the chain
            cascade_n_ff <= !(!chip_enable_n_in && oe_reset_in && past_tc_ff);
            // [R6] Low-power standby flag
            standby_ff   <= chip_enable_n_in;
        end
    end

    assign cascade_enable_out_n = cascade_n_ff;
    assign standby_out          = standby_ff;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!reset_n_in);

    sequence seq_enabled_rise;
        $rose(run) ##0 !past_tc_ff;
    endsequence

    sequence seq_driven_soon;
        ##[1:2] (config_byte_oe_n_out[0] == 1'b0);
    endsequence

    chk_count_advance: assert property ( // [R1]
        (run && clk_rise && !past_tc_ff && count_ff != last_cnt)
        |=> count_ff == $past(count_ff) + 22'h000001)
        else $error("counter did not advance");

    chk_oe_hold: assert property ( // [R2]
        (!oe_reset_in) |=> (count_ff == prom_read_pkg::COUNT_RESET && !past_tc_ff))
        else $error("counter not held at start");

    chk_oe_float: assert property ( // [R3]
        (!oe_reset_in) |=> config_byte_oe_n_out == prom_read_pkg::OE_N_ALL_OFF)
        else $error("data driven while output enable low");

    chk_reset_pull: assert property ( // [R4]
        (hold_cnt_ff > 4'h1) |-> (oe_reset_oe_n_out == 1'b0 && oe_reset_out == 1'b0))
        else $error("shared pin not pulled during reset");

    chk_ce_standby: assert property ( // [R6]
        chip_enable_n_in |=> (standby_out && count_ff == prom_read_pkg::COUNT_RESET
                              && config_byte_oe_n_out == prom_read_pkg::OE_N_ALL_OFF))
        else $error("standby entry incomplete");

    chk_serial_upper: assert property ( // [R7]
        (straps_ok_ff && !parallel_ff)
        |-> config_byte_oe_n_out[7:1] == prom_read_pkg::OE_N_UPPER_OFF)
        else $error("upper pins driven in serial mode");

    chk_parallel_byte: assert property ( // [R8]
        (run && parallel_ff && !past_tc_ff && straps_ok_ff && !pull_low_ff)
        |=> (config_byte_out == $past(array_data_in)
             && config_byte_oe_n_out == prom_read_pkg::OE_N_ALL_ON))
        else $error("parallel byte not presented");

    chk_first_data: assert property ( // [R9]
        (seq_enabled_rise ##0 !pull_low_ff) |-> seq_driven_soon)
        else $error("first data not driven after enable");

    chk_cascade_low: assert property ( // [R18]
        1'b1 |=> cascade_enable_out_n ==
                 $past(!(!chip_enable_n_in && oe_reset_in && past_tc_ff)))
        else $error("cascade output wrong");

    chk_tc_hold: assert property ( // [R20]
        (past_tc_ff && run) |=> (past_tc_ff && count_ff == $past(count_ff)))
        else $error("counter moved past terminal count");

    chk_past_release: assert property ( // [R19]
        past_tc_ff |=> config_byte_oe_n_out == prom_read_pkg::OE_N_ALL_OFF)
        else $error("data driven after terminal count");

    // While enabled, the counter moves only on a counted pin edge
    chk_no_stray_count: assert property ( // [R10]
        (!clk_rise && !chip_enable_n_in && oe_reset_in) |=> count_ff == $past(count_ff))
        else $error("counter moved without pin edge");

    // Data must stand between pin edges so the receiver can take it
    chk_data_stands: assert property ( // [R11]
        (run && !clk_rise && state == prom_read_pkg::ST_READ
         && $past(state == prom_read_pkg::ST_READ && run && !clk_rise))
        |=> $stable(config_byte_out))
        else $error("data changed between pin edges");

    // Cascade returns high as soon as either enable drops
    chk_cascade_high: assert property ( // [R17]
        (chip_enable_n_in || !oe_reset_in) |=> cascade_enable_out_n)
        else $error("cascade low while disabled");

    // Standby flag follows chip enable back down
    chk_standby_exit: assert property ( // [R6]
        !chip_enable_n_in |=> !standby_out)
        else $error("standby flag stuck");

    // Shared pin released once the reset timer has run out
    chk_pull_release: assert property ( // [R4]
        (hold_cnt_ff == 4'h0) |-> oe_reset_oe_n_out)
        else $error("shared pin still pulled");

    // Straps are frozen once captured
    chk_strap_hold: assert property ( // [R16]
        straps_ok_ff |=> ($stable(capacity_ff) && $stable(parallel_ff)))
        else $error("captured straps changed");

endmodule

// >>> tb/cfg_receiver.sv
// Behavioural model of the configuration logic on the far side of the read port.
// Assumes the bench's 10 MHz clock; it acts on falling edges, as the bench does.
`timescale 1ns/1ps
module cfg_receiver (
    input  wire logic       clock_in,
    input  wire logic       start_in,
    input  wire logic [7:0] pulses_in,
    input  wire logic       hold_low_in,
    input  wire logic       oe_pull_n_in,
    input  wire logic [7:0] pins_in,
    output logic            config_clock_out,
    output logic            oe_wire_out,
    output logic            got_out,
    output logic [7:0]      got_byte_out
);
    logic [7:0] left;   // Pulses still to issue
    logic [1:0] phase;  // Quarter of the pin clock period

    ////////////////////////////////////////////////////////////////////////
    // Open-drain reset wire with pull-up: low if either side pulls
    assign oe_wire_out = oe_pull_n_in & ~hold_low_in;

    initial begin
        config_clock_out     = 1'b0;
        got_out      = 1'b0;
        got_byte_out = 8'h00;
        left         = 8'h00;
        phase        = 2'h0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin clock: two cycles high, two low; stands low between bursts
    always @(negedge clock_in) begin
        got_out <= 1'b0;
        if (start_in) begin
            left  <= pulses_in;
            phase <= 2'h0;
        end else if (left != 8'h00) begin
            phase <= phase + 2'h1;
            if (phase == 2'h0) begin
                config_clock_out     <= 1'b1;
                got_out      <= 1'b1;
                got_byte_out <= pins_in;
            end
            if (phase == 2'h2) begin
                config_clock_out <= 1'b0;
                left     <= left - 8'h01;
            end
        end
    end
endmodule

// >>> tb/tb_top.sv
// Self-checking bench for the configuration read port.
// Assumes one 10 MHz clock; the far side is the cfg_receiver model.
`timescale 1ns/1ps
module tb_top;
    logic        clock_in = 1'b0;
    logic        reset_n_in = 1'b0;
    logic        chip_enable_n_in = 1'b1;
    logic        parallel_mode_in = 1'b0;
    logic [1:0]  capacity_sel_in = 2'h0;
    logic        start = 1'b0;
    logic [7:0]  pulses = 8'h00;
    logic        hold_low = 1'b0;
    logic        config_clock, oe_wire, got, oe_pull_n, cascade_n, standby, oe_level;
    logic [7:0]  got_byte, pins, pins_oe_n, array_data;
    logic [18:0] addr;
    int          num_errors = 0;
    int          n_compared = 0;
    int          cycles = 0;

    // Stored pattern of the external array, distinct across any 256 consecutive addresses
    function automatic logic [7:0] pat(input logic [18:0] a);
        return a[7:0] * 8'h1D + 8'h3B;
    endfunction
    assign array_data = pat(addr);

    always #50 clock_in = ~clock_in;

    ////////////////////////////////////////////////////////////////////////
    config_prom_read_port i_dut (
        .clock_in(clock_in), .reset_n_in(reset_n_in), .config_clock_in(config_clock),
        .chip_enable_n_in(chip_enable_n_in), .oe_reset_in(oe_wire),
        .parallel_mode_in(parallel_mode_in), .capacity_sel_in(capacity_sel_in),
        .array_data_in(array_data), .array_addr_out(addr), .config_byte_out(pins),
        .config_byte_oe_n_out(pins_oe_n), .oe_reset_out(oe_level),
        .oe_reset_oe_n_out(oe_pull_n), .cascade_enable_out_n(cascade_n),
        .standby_out(standby));
    cfg_receiver i_rx (
        .clock_in(clock_in), .start_in(start), .pulses_in(pulses),
        .hold_low_in(hold_low), .oe_pull_n_in(oe_pull_n), .pins_in(pins),
        .config_clock_out(config_clock), .oe_wire_out(oe_wire), .got_out(got), .got_byte_out(got_byte));

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [18:0] seen, input logic [18:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Hang guard: the tests need well under a thousand cycles
    always @(posedge clock_in) begin
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            complete_run();
        end
    end

    // Falling edges only, so the design samples settled inputs
    task automatic idle(input int n);
        repeat (n) @(negedge clock_in);
    endtask

    // Ask the receiver for a burst of pin clock pulses
    task automatic burst(input logic [7:0] n);
        @(negedge clock_in);
        start  <= 1'b1;
        pulses <= n;
        @(negedge clock_in);
        start  <= 1'b0;
    endtask

    // Bounded wait for the receiver's capture strobe
    task automatic wait_got();
        int n;
        n = 0;
        @(posedge clock_in);
        while (got !== 1'b1 && n < 20) begin
            @(posedge clock_in);
            n++;
        end
        check(got, 1'b1);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Reset with straps, then watch the internal reset pull on the wire
    task automatic do_reset(input logic par, input logic [1:0] cap);
        @(negedge clock_in);
        reset_n_in       <= 1'b0;
        chip_enable_n_in <= 1'b0;
        parallel_mode_in <= par;
        capacity_sel_in  <= cap;
        idle(2);
        reset_n_in <= 1'b1;
        idle(5);
        check(oe_pull_n, 1'b0);
        check(oe_level, 1'b0);
        check(pins_oe_n, 8'hFF);
        check(addr, 19'h0);
        idle(7);
        check(oe_pull_n, 1'b1);
        $display("test reset done");
    endtask

    task automatic t_serial();
        int i;
        logic [7:0] b;
        do_reset(1'b0, 2'h3);
        idle(3);
        b = pat(19'h0);
        check(pins_oe_n, 8'hFE);
        check(pins[0], b[7]);
        burst(8'd16);
        for (i = 0; i < 16; i++) begin
            wait_got();
            b = pat(19'(i >> 3));
            check(got_byte[0], b[7 - (i & 7)]);
        end
        idle(6);
        check(addr, 19'h2);
        check(cascade_n, 1'b1);
        $display("test serial done");
    endtask

    task automatic t_parallel();
        int i;
        do_reset(1'b1, 2'h0);
        idle(3);
        check(pins_oe_n, 8'h00);
        check(pins, pat(19'h0));
        burst(8'd8);
        for (i = 0; i < 8; i++) begin
            wait_got();
            check(got_byte, pat(19'(i)));
        end
        idle(6);
        check(addr, 19'h8);
        $display("test parallel done");
    endtask

    // Wire pulled low mid-stream: counter held, pins float, edges ignored
    task automatic t_oe_abort();
        hold_low <= 1'b1;
        idle(3);
        check(pins_oe_n, 8'hFF);
        check(cascade_n, 1'b1);
        burst(8'd4);
        idle(20);
        check(addr, 19'h0);
        hold_low <= 1'b0;
        idle(3);
        check(pins_oe_n, 8'h00);
        check(pins, pat(19'h0));
        $display("test oe abort done");
    endtask

    task automatic t_standby();
        burst(8'd3);
        idle(14);
        chip_enable_n_in <= 1'b1;
        idle(3);
        check(standby, 1'b1);
        check(pins_oe_n, 8'hFF);
        check(cascade_n, 1'b1);
        burst(8'd4);
        idle(20);
        check(addr, 19'h0);
        chip_enable_n_in <= 1'b0;
        idle(3);
        check(standby, 1'b0);
        check(pins, pat(19'h0));
        $display("test standby done");
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        idle(2);
        t_serial();
        t_parallel();
        t_oe_abort();
        t_standby();
        complete_run();
    end
endmodule
